/* File: core/bpch_config_header.sv */
// Function-0 bridge configuration header: identity words and command word.
// Assumes configuration cycles already decoded to function 0, one dword per request.
`timescale 1ns/1ps
`include "bpch_params.svh"
module bpch_config_header #(
    parameter logic [15:0] VENDOR_CODE = `BPCH_VID_DEFAULT, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = `BPCH_DID_DEFAULT  // Arbitrary value
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire bpch_pkg::bpch_dw_t cfg_dw_i,
    input wire bpch_pkg::bpch_be_t cfg_be_i,
    input wire bpch_pkg::bpch_dword_t cfg_wdata_i,
    input wire logic dly_timeout_i,
    input wire logic delayed_completion_control_i,
    input wire logic special_cycle_i,
    input wire bpch_pkg::bpch_word_t special_msg_i,
    output logic cfg_ack_o,
    output bpch_pkg::bpch_dword_t cfg_rdata_o,
    output logic serr_o,
    output logic shutdown_o,
    output logic bus_master_en_o,
    output logic mem_en_o,
    output logic io_en_o
);
    import bpch_pkg::*;
    bpch_cmd_if cmd_bus ();
    logic cmd_sel;

    // Dword decode shared by the write path, the read path and the checks
    function automatic logic is_id_dw(input bpch_dw_t dw);
        return dw == `BPCH_DW_ID;
    endfunction
    function automatic logic is_cmd_dw(input bpch_dw_t dw);
        return dw == `BPCH_DW_CMD;
    endfunction

    // Only function-0 configuration cycles arrive here, byte lanes via enables
    assign cmd_sel = cfg_wr_i && is_cmd_dw(cfg_dw_i);
    assign cmd_bus.wr_lo = cmd_sel && cfg_be_i[`BPCH_BE_CMD_LO];
    assign cmd_bus.wr_hi = cmd_sel && cfg_be_i[`BPCH_BE_CMD_HI];
    assign cmd_bus.wdata = cfg_wdata_i[15:0];

    bpch_cmd_reg u_cmd (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .port(cmd_bus.store)
    );

    function automatic bpch_dword_t read_dw(input bpch_dw_t dw, input bpch_word_t cmd);
        bpch_dword_t v;
        v = 32'h0000_0000;
        if (is_id_dw(dw)) begin
            v = {DEVICE_CODE, VENDOR_CODE};
        end else if (is_cmd_dw(dw)) begin
            v = {16'h0000, cmd};
        end
        return v;
    endfunction

    // Read data and acknowledge, one cycle after the request
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            cfg_ack_o <= cfg_rd_i || cfg_wr_i;
            cfg_rdata_o <= cfg_rd_i ? read_dw(cfg_dw_i, cmd_bus.cmd) : 32'h0000_0000;
        end
    end

    // Time-out reporting
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            serr_o <= 1'b0;
        end else begin
            serr_o <= dly_timeout_i && delayed_completion_control_i
                && cmd_bus.cmd[`BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT];
        end
    end

    // Shutdown special cycle recognition
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            shutdown_o <= 1'b0;
        end else begin
            shutdown_o <= special_cycle_i && (special_msg_i == `BPCH_MSG_SHUTDOWN)
                && cmd_bus.cmd[`BPCH_CMD_SCE_BIT];
        end
    end

    // Enables taken from the hardwired command bits
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bus_master_en_o <= 1'b0;
            mem_en_o <= 1'b0;
            io_en_o <= 1'b0;
        end else begin
            bus_master_en_o <= cmd_bus.cmd[`BPCH_CMD_BME_BIT];
            mem_en_o <= cmd_bus.cmd[`BPCH_CMD_MEM_BIT];
            io_en_o <= cmd_bus.cmd[`BPCH_CMD_IO_BIT];
        end
    end

    sequence seq_timeout_enabled;
        dly_timeout_i && delayed_completion_control_i && cmd_bus.cmd[`BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT];
    endsequence
    sequence seq_shutdown_accepted;
        special_cycle_i && cmd_bus.cmd[`BPCH_CMD_SCE_BIT]
            && (special_msg_i == `BPCH_MSG_SHUTDOWN);
    endsequence
    sequence seq_cmd_read;
        cfg_rd_i && is_cmd_dw(cfg_dw_i);
    endsequence
    sequence seq_unmapped_read;
        cfg_rd_i && !is_id_dw(cfg_dw_i) && !is_cmd_dw(cfg_dw_i);
    endsequence
    sequence seq_lone_timeout;
        seq_timeout_enabled ##1 !dly_timeout_i;
    endsequence
    sequence seq_lone_shutdown;
        seq_shutdown_accepted ##1 !special_cycle_i;
    endsequence

    AST_ID_READ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (cfg_rd_i && cfg_dw_i == `BPCH_DW_ID) |=>
            cfg_ack_o && cfg_rdata_o[15:0] == VENDOR_CODE)
        else $error("vendor code read wrong");
    AST_DID_READ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (cfg_rd_i && cfg_dw_i == `BPCH_DW_ID) |=> cfg_rdata_o[31:16] == DEVICE_CODE)
        else $error("device code read wrong");
    AST_CMD_AFTER_RESET: assert property (@(posedge clock_i)
        (($rose(rst_n_i) && !cfg_wr_i) ##1 seq_cmd_read)
            |=> cfg_rdata_o == {16'h0000, `BPCH_CMD_RESET})
        else $error("command word not at reset value");
    AST_SERR_RAISED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_timeout_enabled |=> serr_o)
        else $error("time-out did not raise system error");
    AST_SERR_BLOCKED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !cmd_bus.cmd[`BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT] |=> !serr_o)
        else $error("system error raised while disabled");
    AST_SHUTDOWN_SEEN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_shutdown_accepted |=> shutdown_o)
        else $error("shutdown special cycle missed");
    AST_SPECIAL_IGNORED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !cmd_bus.cmd[`BPCH_CMD_SCE_BIT] |=> !shutdown_o)
        else $error("special cycle seen while disabled");
    AST_ENABLES_ON: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(rst_n_i) ##1 1'b1 |-> bus_master_en_o && mem_en_o && io_en_o)
        else $error("hardwired enables not on");

    // Config port answers every request for one cycle
    AST_ACK_FOLLOWS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (cfg_rd_i || cfg_wr_i) |=> cfg_ack_o)
        else $error("request not acknowledged");
    AST_ACK_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !(cfg_rd_i || cfg_wr_i) |=> !cfg_ack_o)
        else $error("acknowledge without request");
    AST_RDATA_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !cfg_rd_i |=> cfg_rdata_o == 32'h0000_0000)
        else $error("read data not zero outside reads");
    AST_UNMAPPED_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_unmapped_read |=> cfg_rdata_o == 32'h0000_0000)
        else $error("unmapped dword not zero");
    AST_UNMAPPED_ACK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_unmapped_read |=> cfg_ack_o)
        else $error("unmapped read not acknowledged");

    // Read path shows the command bits as stored and hardwired
    AST_CMD_READ_ACK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> cfg_ack_o)
        else $error("command read not acknowledged");
    AST_CMD_HIGH_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> cfg_rdata_o[31:16] == 16'h0000)
        else $error("upper half of command dword not zero");
    AST_READ_RSVD_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> (cfg_rdata_o[15:0] & `BPCH_CMD_RSVD_MASK) == 16'h0000)
        else $error("reserved bits read nonzero");
    AST_READ_FBB_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> !cfg_rdata_o[`BPCH_CMD_FBB_BIT])
        else $error("fast back-to-back bit read nonzero");
    AST_READ_PMW_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> !cfg_rdata_o[`BPCH_CMD_PMW_BIT])
        else $error("postable write bit read nonzero");
    AST_READ_BME_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> cfg_rdata_o[`BPCH_CMD_BME_BIT])
        else $error("bus master bit read zero");
    AST_READ_MEM_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> cfg_rdata_o[`BPCH_CMD_MEM_BIT])
        else $error("memory enable bit read zero");
    AST_READ_IO_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_cmd_read |=> cfg_rdata_o[`BPCH_CMD_IO_BIT])
        else $error("io enable bit read zero");

    // Event outputs need their cause and last one cycle
    AST_SERR_NEEDS_TIMEOUT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !dly_timeout_i |=> !serr_o)
        else $error("system error without time-out");
    AST_SERR_NEEDS_CONTROL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !delayed_completion_control_i |=> !serr_o)
        else $error("system error with control bit clear");
    AST_SERR_PULSE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_lone_timeout |-> serr_o ##1 !serr_o)
        else $error("system error not a single pulse");
    AST_SHUTDOWN_NEEDS_CYCLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !special_cycle_i |=> !shutdown_o)
        else $error("shutdown without special cycle");
    AST_OTHER_SPECIAL_IGNORED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (special_msg_i != `BPCH_MSG_SHUTDOWN) |=> !shutdown_o)
        else $error("non-shutdown special cycle accepted");
    AST_SHUTDOWN_PULSE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        seq_lone_shutdown |-> shutdown_o ##1 !shutdown_o)
        else $error("shutdown not a single pulse");

    // Hardwired enables stay on after reset
    AST_BME_STEADY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> bus_master_en_o)
        else $error("bus master enable dropped");
    AST_MEM_STEADY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> mem_en_o)
        else $error("memory enable dropped");
    AST_IO_STEADY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> io_en_o)
        else $error("io enable dropped");
endmodule

/* File: core/bpch_params.svh */
// Constants for the bridge configuration header: offsets, fields, reset values.
// Assumes inclusion by bare name from the core files.
// Behaviour
// - Vendor code, 16 bits, read-only at offset 00h; writes change nothing.
// - Device code, 16 bits, read-only at offset 02h; identifies bridge with vendor code.
// - Command register at offset 04h, reads 0007h after reset.
// - Command bit 9, fast back-to-back, reads 0 and ignores writes.
// - Bit 8 with delayed-completion control bit 3 lets a time-out raise system error.
// - Command bit 4, postable memory write, hardwired to 0.
// - Bit 3 set accepts shutdown special cycles; clear ignores all special cycles.
// - Command bit 2, bus master enable, hardwired to 1.
// - Command bit 1, memory space enable, hardwired to 1.
// - Command bit 0, I/O space enable, hardwired to 1.
`ifndef BPCH_PARAMS_SVH
`define BPCH_PARAMS_SVH
`define BPCH_DW_ID 6'h00
`define BPCH_DW_CMD 6'h01
`define BPCH_CMD_RESET 16'h0007
`define BPCH_CMD_HARD1 16'h0007
`define BPCH_CMD_WMASK 16'h0108
`define BPCH_CMD_RSVD_MASK 16'hFCE0
`define BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT 8
`define BPCH_CMD_SCE_BIT 3
`define BPCH_CMD_FBB_BIT 9
`define BPCH_CMD_PMW_BIT 4
`define BPCH_CMD_BME_BIT 2
`define BPCH_CMD_MEM_BIT 1
`define BPCH_CMD_IO_BIT 0
`define BPCH_BE_CMD_LO 0
`define BPCH_BE_CMD_HI 1
`define BPCH_MSG_SHUTDOWN 16'h0000
`define BPCH_VID_DEFAULT 16'h0A5A
`define BPCH_DID_DEFAULT 16'h0C3C
`endif

/* File: core/bpch_pkg.sv */
// Types shared by the bridge configuration header modules.
// Assumes nothing beyond a SystemVerilog compiler.
package bpch_pkg;
    typedef logic [15:0] bpch_word_t;
    typedef logic [31:0] bpch_dword_t;
    typedef logic [5:0] bpch_dw_t;
    typedef logic [3:0] bpch_be_t;
endpackage

/* File: core/bpch_cmd_if.sv */
// Carrier between the header decode and the command word store.
// Assumes one clock domain.
`timescale 1ns/1ps
interface bpch_cmd_if;
    import bpch_pkg::*;
    logic wr_lo;
    logic wr_hi;
    bpch_word_t wdata;
    bpch_word_t cmd;
    modport ctl (output wr_lo, output wr_hi, output wdata, input cmd);
    modport store (input wr_lo, input wr_hi, input wdata, output cmd);
endinterface

/* File: core/bpch_cmd_reg.sv */
// Command word store: writable enables plus hardwired bits.
// Assumes byte write strobes already decoded for the command dword.
`timescale 1ns/1ps
`include "bpch_params.svh"
module bpch_cmd_reg (
    input wire logic clock_i,
    input wire logic rst_n_i,
    bpch_cmd_if.store port
);
    import bpch_pkg::*;
    logic system_error_report_enable;
    logic special_cycle_accept;

    // System error enable in the high byte
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            system_error_report_enable <= 1'b0;
        end else if (port.wr_hi) begin
            system_error_report_enable <= port.wdata[`BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT];
        end
    end

    // Special cycle accept in the low byte
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            special_cycle_accept <= 1'b0;
        end else if (port.wr_lo) begin
            special_cycle_accept <= port.wdata[`BPCH_CMD_SCE_BIT];
        end
    end

    // Hardwired ones, zeros elsewhere
    always_comb begin
        port.cmd = `BPCH_CMD_HARD1;
        port.cmd[`BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT] = system_error_report_enable;
        port.cmd[`BPCH_CMD_SCE_BIT] = special_cycle_accept;
    end

    AST_FBB_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port.wr_hi |=> !port.cmd[`BPCH_CMD_FBB_BIT])
        else $error("fast back-to-back bit not zero after write");
    AST_PMW_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port.wr_lo |=> !port.cmd[`BPCH_CMD_PMW_BIT])
        else $error("postable write bit not zero after write");
    AST_BME_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port.wr_lo |=> port.cmd[`BPCH_CMD_BME_BIT])
        else $error("bus master bit not one after write");
    AST_MEM_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port.wr_lo |=> port.cmd[`BPCH_CMD_MEM_BIT])
        else $error("memory enable bit not one after write");
    AST_IO_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port.wr_lo |=> port.cmd[`BPCH_CMD_IO_BIT])
        else $error("io enable bit not one after write");
    AST_RSVD_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (port.wr_lo || port.wr_hi) |=> ((port.cmd & `BPCH_CMD_RSVD_MASK) == 16'h0000))
        else $error("reserved command bits not zero");
    AST_SYSTEM_ERROR_REPORT_ENABLE_STORE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port.wr_hi |=> port.cmd[`BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT] == $past(port.wdata[`BPCH_CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT]))
        else $error("system error enable not stored");
    AST_SCE_STORE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port.wr_lo |=> port.cmd[`BPCH_CMD_SCE_BIT] == $past(port.wdata[`BPCH_CMD_SCE_BIT]))
        else $error("special cycle accept not stored");
endmodule

/* File: sim/bpch_host_model.sv */
// Host bridge model: issues function-0 configuration reads and writes.
// Assumes a one-cycle acknowledge from the header after each request.
`timescale 1ns/1ps
module bpch_host_model (
    input wire logic clock_i,
    input wire logic cfg_ack_i,
    input wire bpch_pkg::bpch_dword_t cfg_rdata_i,
    output logic cfg_rd_o,
    output logic cfg_wr_o,
    output bpch_pkg::bpch_dw_t cfg_dw_o,
    output bpch_pkg::bpch_be_t cfg_be_o,
    output bpch_pkg::bpch_dword_t cfg_wdata_o
);
    import bpch_pkg::*;
    initial begin
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_dw_o = 6'h00;
        cfg_be_o = 4'h0;
        cfg_wdata_o = 32'h0000_0000;
    end
    // One request pulse, then wait a bounded time for the acknowledge
    task automatic access(input logic w, input bpch_dw_t d, input bpch_be_t b,
                          input bpch_dword_t v, output bpch_dword_t r, output logic a);
        int n;
        n = 0;
        @(posedge clock_i);
        cfg_rd_o <= !w;
        cfg_wr_o <= w;
        cfg_dw_o <= d;
        cfg_be_o <= b;
        cfg_wdata_o <= v;
        @(posedge clock_i);
        cfg_rd_o <= 1'b0;
        cfg_wr_o <= 1'b0;
        while (cfg_ack_i !== 1'b1 && n < 8) begin
            @(posedge clock_i);
            n++;
        end
        r = cfg_rdata_i;
        a = (cfg_ack_i === 1'b1) && (n == 1);
    endtask
endmodule

/* File: sim/tb.sv */
// Testbench: drives the header through the host model and checks results.
// Assumes the core files and the host model are compiled first.
`timescale 1ns/1ps
module tb;
    import bpch_pkg::*;
    localparam bpch_word_t VC = 16'h1A2B; // Arbitrary value
    localparam bpch_word_t DC = 16'h3C4D; // Arbitrary value
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rd, wr, ack, serr, shut, bme, mem, io;
    logic dto = 1'b0;
    logic dcc = 1'b0;
    logic spc = 1'b0;
    bpch_word_t msg = 16'h0000;
    bpch_dw_t dw;
    bpch_be_t be;
    bpch_dword_t wd, rdat;
    int errors = 0;
    int samples_checked = 0;
    always #5 clock_i = ~clock_i;
    bpch_config_header #(.VENDOR_CODE(VC), .DEVICE_CODE(DC)) i_bpch_config_header (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_rd_i(rd), .cfg_wr_i(wr),
        .cfg_dw_i(dw), .cfg_be_i(be), .cfg_wdata_i(wd), .dly_timeout_i(dto),
        .delayed_completion_control_i(dcc), .special_cycle_i(spc),
        .special_msg_i(msg), .cfg_ack_o(ack), .cfg_rdata_o(rdat), .serr_o(serr),
        .shutdown_o(shut), .bus_master_en_o(bme), .mem_en_o(mem), .io_en_o(io));
    bpch_host_model i_bpch_host_model (
        .clock_i(clock_i), .cfg_ack_i(ack), .cfg_rdata_i(rdat), .cfg_rd_o(rd),
        .cfg_wr_o(wr), .cfg_dw_o(dw), .cfg_be_o(be), .cfg_wdata_o(wd));
    task automatic check_dw(input bpch_dword_t got, input bpch_dword_t exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t dword %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic put(input bpch_dw_t d, input bpch_be_t b, input bpch_dword_t v);
        bpch_dword_t r;
        logic a;
        i_bpch_host_model.access(1'b1, d, b, v, r, a);
        check_bit(a, 1'b1);
        check_dw(r, 32'h0000_0000);
    endtask
    task automatic get(input bpch_dw_t d, output bpch_dword_t r);
        logic a;
        i_bpch_host_model.access(1'b0, d, 4'h0, 32'h0000_0000, r, a);
        check_bit(a, 1'b1);
    endtask
    // Time-out and special cycle in the same cycle, outputs checked one cycle later
    task automatic pulse(input logic c, input bpch_word_t m, input logic es, input logic eh);
        @(posedge clock_i);
        dto <= 1'b1;
        spc <= 1'b1;
        msg <= m;
        dcc <= c;
        @(posedge clock_i);
        dto <= 1'b0;
        spc <= 1'b0;
        @(posedge clock_i);
        check_bit(serr, es);
        check_bit(shut, eh);
        @(posedge clock_i);
        check_bit(serr, 1'b0);
        check_bit(shut, 1'b0);
    endtask
    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
    initial begin
        bpch_dword_t r;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        get(6'h00, r);
        check_dw(r, {DC, VC});
        get(6'h01, r);
        check_dw(r, 32'h0000_0007);
        check_bit(bme, 1'b1);
        check_bit(mem, 1'b1);
        check_bit(io, 1'b1);
        put(6'h00, 4'hF, 32'hFFFF_FFFF);
        get(6'h00, r);
        check_dw(r, {DC, VC});
        put(6'h01, 4'hF, 32'hFFFF_FFFF);
        get(6'h01, r);
        check_dw(r, 32'h0000_010F);
        put(6'h01, 4'h1, 32'h0000_0000);
        get(6'h01, r);
        check_dw(r, 32'h0000_0107);
        put(6'h01, 4'hF, 32'h0000_0000);
        get(6'h01, r);
        check_dw(r, 32'h0000_0007);
        put(6'h01, 4'hC, 32'hFFFF_FFFF);
        put(6'h02, 4'hF, 32'hFFFF_FFFF);
        get(6'h01, r);
        check_dw(r, 32'h0000_0007);
        get(6'h02, r);
        check_dw(r, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            put(6'h01, 4'h3, {23'h0, k[1], 4'h0, k[0], 3'h0});
            get(6'h01, r);
            check_dw(r, {16'h0, 7'h0, k[1], 4'h0, k[0], 3'h7});
            pulse(k[2], 16'h0000, k[1] & k[2], k[0]);
        end
        pulse(1'b1, 16'h0001, 1'b1, 1'b0);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        get(6'h01, r);
        check_dw(r, 32'h0000_0007);
        check_bit(bme, 1'b1);
        check_bit(mem, 1'b1);
        check_bit(io, 1'b1);
        give_verdict();
    end
endmodule
